//--- sim/ddr_psram_fabric_port_tb.sv
// bench: controller and port joined by the link, memory pins played by the bench
`timescale 1ns/10ps
module ddr_psram_fabric_port_tb import dpf_pkg::*; ;
    logic               clk_sys = 0, rst_b = 0, req_valid = 0, req_write = 0, wr_valid = 0;
    logic [ADDR_W-1:0]  req_addr = '0;
    logic [FIFO_W-1:0]  wr_data = '0, rd_data;
    logic               req_ready, wr_ready, rd_valid, mem_ready, ck_p, ck_n, cs_pin_b, mrst_pin_b;
    logic [DQ_W-1:0]    dq_i, dq_o, dq_oe_b, mem_dq = 16'h5a3c, last_dq = '0;
    logic [STB_W-1:0]   rwds_i, rwds_o, rwds_oe_b, mem_rwds = 2'h0;
    logic [DQ_W-1:0]    ca[$], wd[$];
    int                 n_mismatch = 0, checks = 0, cyc = 0, t;
    dpf_link_if link();
    dpf_ctrl i_dpf_ctrl (.clk_sys(clk_sys), .rst_b(rst_b), .link(link.ctrl), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_ready(req_ready), .wr_valid(wr_valid),
        .wr_data(wr_data), .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid), .mem_ready(mem_ready));
    dpf_port i_dpf_port (.clk_sys(clk_sys), .rst_b(rst_b), .link(link.port), .ck_p_o(ck_p), .ck_n_o(ck_n),
        .cs_pin_b(cs_pin_b), .mem_rst_pin_b(mrst_pin_b), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_b(dq_oe_b),
        .rwds_i(rwds_i), .rwds_o(rwds_o), .rwds_oe_b(rwds_oe_b));
    dpf_props i_props (.clk_sys(clk_sys), .rst_b(rst_b), .ctrl_clock(link.ctrl_clock),
        .ctrl_clock_quadrature(link.ctrl_clock_quadrature), .mem_rst_b(link.mem_rst_b), .cs_b(link.cs_b),
        .capture_calibration_clock(link.capture_calibration_clock), .lanes_drive_enable(link.lanes_drive_enable),
        .memclk_pos_rise_half(link.memclk_pos_rise_half), .memclk_pos_fall_half(link.memclk_pos_fall_half),
        .memclk_neg_rise_half(link.memclk_neg_rise_half), .memclk_neg_fall_half(link.memclk_neg_fall_half),
        .strobe_tx_rise_half(link.strobe_tx_rise_half), .strobe_tx_fall_half(link.strobe_tx_fall_half),
        .strobe_drive_enable(link.strobe_drive_enable));
    // a pin shows the port's value while driven, else the memory's
    assign dq_i = (dq_o & ~dq_oe_b) | (mem_dq & dq_oe_b);
    assign rwds_i = (rwds_o & ~rwds_oe_b) | (mem_rwds & rwds_oe_b);
    initial forever #50 clk_sys = ~clk_sys;
    // log each new driven lane value; strobe driven marks write data
    always @(posedge clk_sys) begin
        if (dq_oe_b == '0 && dq_o !== last_dq) begin
            last_dq = dq_o;
            if (rwds_oe_b == '1) ca.push_back(dq_o);
            else wd.push_back(dq_o);
        end
    end
    // hang guard on the whole run, well above its ten bursts of under two hundred cycles each
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            conclude();
        end
    end
    task step();
        @(posedge clk_sys) #1;
    endtask
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task conclude();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // valid stays up between words; the caller drops it after the last one
    task push(input logic [31:0] w);
        wr_valid = 1;
        wr_data = w;
        while (wr_ready !== 1'b1) step();
        step();
    endtask
    // one transaction; t ends as cycles from take to the first read pair
    task xfer(input logic w, input logic [ADDR_W-1:0] a);
        ca.delete();
        wd.delete();
        req_valid = 1;
        req_write = w;
        req_addr = a;
        while (req_ready !== 1'b1) step();
        step();
        req_valid = 0;
        step();
        chk("select pin", cs_pin_b, 0);
        t = 0;
        for (int i = 0; i < 2 && !w; i++) begin
            while (rd_valid !== 1'b1) begin
                step();
                t += (i == 0);
            end
            chk("read pair", rd_data, {mem_dq, mem_dq});
            step();
        end
        while (link.cs_b !== 1'b1) step();
        chk("parked clock", {ck_p, ck_n}, 2'h1);
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        #1 rst_b = 1;
        while (mem_ready !== 1'b1) step();
        // the port passes the reset level on one cycle later
        step();
        chk("memory reset pin", mrst_pin_b, 1);
        // fill the fifo until it refuses
        for (int k = 0; k < 16; k++) push({16'h1100 | k[15:0], 16'h2200 | k[15:0]});
        wr_valid = 0;
        chk("fifo full", wr_ready, 0);
        $display("fill test done");
        // eight bursts of two words drain it, rise word before fall word
        for (int b = 0; b < 8; b++) begin
            xfer(1, 24'h123400 + b);
            chk("write command", ca[0], 16'h0012);
            for (int j = 0; j < 4; j++) chk("write lanes", wd[j], (j % 2 ? 16'h2200 : 16'h1100) | (2 * b + j / 2));
        end
        chk("fifo drained", wr_ready, 1);
        $display("write test done");
        xfer(0, 24'habcdef);
        chk("read command", ca[0], 16'h80ab);
        chk("read address", ca[1], 16'hcdef);
        chk("short latency", t < 100, 1);
        mem_rwds = 2'h3;
        xfer(0, 24'h000100);
        chk("long latency", t > 100, 1);
        $display("read test done");
        conclude();
    end
endmodule

//--- sim/dpf_props.sv
// link checker: clocks, select, memory clock legs, masks and drive enables
`timescale 1ns/10ps
module dpf_props
    import dpf_pkg::*;
(
    input wire logic              clk_sys,                   // clock
    input wire logic              rst_b,                     // reset
    input wire logic              ctrl_clock,                // ctrl clock
    input wire logic              ctrl_clock_quadrature,     // 90 deg copy
    input wire logic              capture_calibration_clock, // capture clock
    input wire logic              mem_rst_b,                 // memory reset
    input wire logic              cs_b,                      // select
    input wire logic              memclk_pos_rise_half,      // true leg rise
    input wire logic              memclk_pos_fall_half,      // true leg fall
    input wire logic              memclk_neg_rise_half,      // inverted leg rise
    input wire logic              memclk_neg_fall_half,      // inverted leg fall
    input wire logic [STB_W-1:0]  strobe_tx_rise_half,       // mask rise
    input wire logic [STB_W-1:0]  strobe_tx_fall_half,       // mask fall
    input wire logic [STB_W-1:0]  strobe_drive_enable,       // strobe drive
    input wire logic [DQ_W-1:0]   lanes_drive_enable         // lane drive
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // quarter period of eight cycles is two cycles
    // the clock's reset value is not phase 0, so skip the first edges after release
    property p_quad; $past(rst_b, 3) |-> ctrl_clock_quadrature == $past(ctrl_clock, 2); endproperty
    a_quad: assert property (p_quad) else $error("quadrature clock misplaced");
    property p_cal; capture_calibration_clock == ctrl_clock_quadrature; endproperty
    a_cal: assert property (p_cal) else $error("capture clock misplaced");
    property p_mrst; $rose(rst_b) |-> !mem_rst_b [*8]; endproperty
    a_mrst: assert property (p_mrst) else $error("memory reset too short");
    property p_cs; $fell(cs_b) |-> !cs_b [*8]; endproperty
    a_cs: assert property (p_cs) else $error("select dropped early");
    // stopped clock outside a transaction, legs always opposite
    property p_stop; cs_b |-> !memclk_pos_rise_half && !memclk_pos_fall_half; endproperty
    a_stop: assert property (p_stop) else $error("memory clock runs while idle");
    property p_legs; {memclk_neg_rise_half, memclk_neg_fall_half} == ~{memclk_pos_rise_half, memclk_pos_fall_half};
    endproperty
    a_legs: assert property (p_legs) else $error("clock legs not opposite");
    property p_mask; strobe_tx_rise_half == 2'h0 && strobe_tx_fall_half == 2'h0; endproperty
    a_mask: assert property (p_mask) else $error("byte mask set");
    property p_oe; (|lanes_drive_enable) |-> !cs_b; endproperty
    a_oe: assert property (p_oe) else $error("lanes driven outside select");
    property p_soe; (|strobe_drive_enable) |-> lanes_drive_enable == 16'hffff; endproperty
    a_soe: assert property (p_soe) else $error("strobe driven without lanes");
endmodule

//--- src/dpf_ctrl.sv
// fabric memory controller with write data fifo, driving the port link
`timescale 1ns/10ps
module dpf_fifo
    import dpf_pkg::*;
#(
    parameter int W     = FIFO_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic                      clk_sys,     // system clock
    input  wire logic                      rst_b,       // sync reset, active low
    input  wire logic                      in_valid,    // word offered
    output logic                           in_ready,    // room left
    input  wire logic [W-1:0]              in_data,     // word in
    output logic                           out_valid,   // word held
    input  wire logic                      out_ready,   // word taken
    output logic      [W-1:0]              out_data,    // head word
    output logic      [$clog2(DEPTH):0]    count        // words held
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0]  mem_r [DEPTH];
    logic [AW:0]   wp_r, wp_nxt, rp_r, rp_nxt;
    logic          push, pop;

    assign count     = wp_r - rp_r;
    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push      = in_valid & in_ready;
    assign pop       = out_ready & out_valid;
    assign out_data  = mem_r[rp_r[AW-1:0]];

    // pointers carry one extra bit so full and empty differ
    always_comb begin
        wp_nxt = push ? (AW+1)'(wp_r + 1'b1) : wp_r;
        rp_nxt = pop ? (AW+1)'(rp_r + 1'b1) : rp_r;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
        end
    end

    // storage needs no reset, reads are gated by count
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_r[wp_r[AW-1:0]] <= in_data;
        end
    end
endmodule

module dpf_ctrl
    import dpf_pkg::*;
(
    input  wire logic                clk_sys,     // system clock
    input  wire logic                rst_b,       // sync reset, active low
    dpf_link_if.ctrl                 link,        // toward the port
    input  wire logic                req_valid,   // transaction request
    input  wire logic                req_write,   // 1 write, 0 read
    input  wire logic [ADDR_W-1:0]   req_addr,    // word address
    output logic                     req_ready,   // request taken
    input  wire logic                wr_valid,    // write word offered
    input  wire logic [FIFO_W-1:0]   wr_data,     // rise word high, fall word low
    output logic                     wr_ready,    // fifo has room
    output logic      [FIFO_W-1:0]   rd_data,     // read word pair
    output logic                     rd_valid,    // one cycle per pair
    output logic                     mem_ready    // memory out of reset
);
    logic [FIFO_W-1:0]           f_data;
    logic                        f_valid, f_pop;
    logic [$clog2(FIFO_DEPTH):0] f_count;

    // pops only in write data periods, so a slow memory backs up the user
    dpf_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_wfifo (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .in_valid  (wr_valid),
        .in_ready  (wr_ready),
        .in_data   (wr_data),
        .out_valid (f_valid),
        .out_ready (f_pop),
        .out_data  (f_data),
        .count     (f_count)
    );

    dpf_state_t          st_r, st_nxt;
    logic [PH_W-1:0]     ph_r, ph_nxt;
    logic [CNT_W-1:0]    cnt_r, cnt_nxt;
    logic [RCNT_W-1:0]   rc_r, rc_nxt;
    logic                mr_r, mr_nxt, cs_r, cs_nxt, wr_r, wr_nxt, dbl_r, dbl_nxt;
    logic                ck_r, ck_nxt, q_r, q_nxt, run_r, run_nxt, pend_r, pend_nxt, rv_r, rv_nxt;
    logic [ADDR_W-1:0]   addr_r, addr_nxt;
    logic [DQ_W-1:0]     lr_r, lr_nxt, lf_r, lf_nxt, le_r, le_nxt;
    logic [STB_W-1:0]    sr_r, sr_nxt, sf_r, sf_nxt, se_r, se_nxt;
    logic [FIFO_W-1:0]   rd_r, rd_nxt;
    logic                pend_end, req_fire;
    logic [CNT_W-1:0]    lat_lim;

    assign pend_end  = (ph_r == PH_LAST);
    assign req_ready = (st_r == DPF_IDLE) & pend_end & mr_r
                     & (~req_write | (f_count >= ($clog2(FIFO_DEPTH)+1)'(BEAT_PERIODS)));
    assign req_fire  = req_valid & req_ready;
    assign lat_lim   = dbl_r ? CNT_W'(LAT_PERIODS << 1) : LAT_PERIODS;
    assign f_pop     = pend_end & (st_nxt == DPF_DATA) & wr_nxt;

    // divider steps every cycle; sequencer and outgoing halves change at period end
    always_comb begin
        ph_nxt   = PH_W'(ph_r + 1'b1);
        ck_nxt   = ~ph_nxt[2];
        q_nxt    = ph_nxt[2] ^ ph_nxt[1];
        rc_nxt   = (rc_r == MEM_RST_CYC) ? rc_r : RCNT_W'(rc_r + 1'b1);
        mr_nxt   = (rc_r == MEM_RST_CYC);
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        cs_nxt   = cs_r;
        wr_nxt   = wr_r;
        dbl_nxt  = dbl_r;
        addr_nxt = addr_r;
        run_nxt  = run_r;
        lr_nxt   = lr_r;
        lf_nxt   = lf_r;
        le_nxt   = le_r;
        sr_nxt   = sr_r;
        sf_nxt   = sf_r;
        se_nxt   = se_r;
        pend_nxt = pend_r;
        rd_nxt   = rd_r;
        rv_nxt   = 1'b0;
        if (pend_end) begin
            cnt_nxt = CNT_W'(cnt_r + 1'b1);
            case (st_r)
                DPF_IDLE: begin
                    if (req_fire) begin
                        st_nxt   = DPF_CMD;
                        cnt_nxt  = '0;
                        cs_nxt   = 1'b0;
                        wr_nxt   = req_write;
                        addr_nxt = req_addr;
                    end else begin
                        cnt_nxt = '0;
                    end
                end
                DPF_CMD: begin
                    if (cnt_r == CMD_PERIODS - 1'b1) begin
                        st_nxt  = DPF_LAT;
                        cnt_nxt = '0;
                        dbl_nxt = |link.strobe_rx_rise_half;  // strobe high asks extra latency
                    end
                end
                DPF_LAT: begin
                    if (cnt_r == lat_lim - 1'b1) begin
                        st_nxt  = DPF_DATA;
                        cnt_nxt = '0;
                    end
                end
                DPF_DATA: begin
                    pend_nxt = ~wr_r;
                    if (cnt_r == BEAT_PERIODS - 1'b1) begin
                        st_nxt  = DPF_DONE;
                        cnt_nxt = '0;
                    end
                end
                DPF_DONE: begin
                    st_nxt = DPF_IDLE;
                    cs_nxt = 1'b1;
                end
                default: begin
                    st_nxt = DPF_IDLE;
                    cs_nxt = 1'b1;
                end
            endcase
            // halves for the coming period; enables stay off otherwise
            lr_nxt  = '0;
            lf_nxt  = '0;
            le_nxt  = '0;
            sr_nxt  = '0;
            sf_nxt  = '0;
            se_nxt  = '0;
            run_nxt = (st_nxt == DPF_CMD) | (st_nxt == DPF_LAT) | (st_nxt == DPF_DATA);
            if (st_nxt == DPF_CMD) begin
                le_nxt = '1;
                if (cnt_nxt == '0) begin
                    lr_nxt = DQ_W'({~wr_nxt, 7'h00, addr_nxt[ADDR_W-1:DQ_W]});
                    lf_nxt = addr_nxt[DQ_W-1:0];
                end
            end else if ((st_nxt == DPF_DATA) & wr_nxt) begin
                lr_nxt = f_data[FIFO_W-1:DQ_W];
                lf_nxt = f_data[DQ_W-1:0];
                le_nxt = '1;
                se_nxt = '1;
                sr_nxt = '0;
                sf_nxt = '0;
            end
        end
        // fall half settles a quarter period into the next period
        if (pend_r & (ph_r == PH_TAKE)) begin
            rd_nxt   = {link.lanes_rx_rise_half, link.lanes_rx_fall_half};
            rv_nxt   = 1'b1;
            pend_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            st_r   <= DPF_IDLE;
            ph_r   <= '0;
            cnt_r  <= '0;
            rc_r   <= '0;
            mr_r   <= 1'b0;
            cs_r   <= 1'b1;
            wr_r   <= 1'b0;
            dbl_r  <= 1'b0;
            addr_r <= '0;
            ck_r   <= 1'b0;
            q_r    <= 1'b0;
            run_r  <= 1'b0;
            lr_r   <= '0;
            lf_r   <= '0;
            le_r   <= '0;
            sr_r   <= '0;
            sf_r   <= '0;
            se_r   <= '0;
            pend_r <= 1'b0;
            rd_r   <= '0;
            rv_r   <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            ph_r   <= ph_nxt;
            cnt_r  <= cnt_nxt;
            rc_r   <= rc_nxt;
            mr_r   <= mr_nxt;
            cs_r   <= cs_nxt;
            wr_r   <= wr_nxt;
            dbl_r  <= dbl_nxt;
            addr_r <= addr_nxt;
            ck_r   <= ck_nxt;
            q_r    <= q_nxt;
            run_r  <= run_nxt;
            lr_r   <= lr_nxt;
            lf_r   <= lf_nxt;
            le_r   <= le_nxt;
            sr_r   <= sr_nxt;
            sf_r   <= sf_nxt;
            se_r   <= se_nxt;
            pend_r <= pend_nxt;
            rd_r   <= rd_nxt;
            rv_r   <= rv_nxt;
        end
    end

    // stopped clock parks true leg low, inverted leg high
    assign link.ctrl_clock                = ck_r;
    assign link.ctrl_clock_quadrature     = q_r;
    assign link.capture_calibration_clock = q_r;
    assign link.mem_rst_b                 = mr_r;
    assign link.cs_b                      = cs_r;
    assign link.memclk_pos_rise_half      = run_r;
    assign link.memclk_pos_fall_half      = 1'b0;
    assign link.memclk_neg_rise_half      = ~run_r;
    assign link.memclk_neg_fall_half      = 1'b1;
    assign link.strobe_tx_rise_half       = sr_r;
    assign link.strobe_tx_fall_half       = sf_r;
    assign link.strobe_drive_enable       = se_r;
    assign link.lanes_tx_rise_half        = lr_r;
    assign link.lanes_tx_fall_half        = lf_r;
    assign link.lanes_drive_enable        = le_r;
    assign rd_data                        = rd_r;
    assign rd_valid                       = rv_r;
    assign mem_ready                      = mr_r;
endmodule

//--- src/dpf_link_if.sv
// fabric side signals between the memory controller and the port
`timescale 1ns/10ps
interface dpf_link_if;
    import dpf_pkg::*;
    logic                ctrl_clock;
    logic                ctrl_clock_quadrature;
    logic                capture_calibration_clock;
    logic                mem_rst_b;
    logic                cs_b;
    logic                memclk_pos_rise_half;
    logic                memclk_pos_fall_half;
    logic                memclk_neg_rise_half;
    logic                memclk_neg_fall_half;
    logic [STB_W-1:0]    strobe_tx_rise_half;
    logic [STB_W-1:0]    strobe_tx_fall_half;
    logic [STB_W-1:0]    strobe_drive_enable;
    logic [DQ_W-1:0]     lanes_tx_rise_half;
    logic [DQ_W-1:0]     lanes_tx_fall_half;
    logic [DQ_W-1:0]     lanes_drive_enable;
    logic [STB_W-1:0]    strobe_rx_rise_half;
    logic [STB_W-1:0]    strobe_rx_fall_half;
    logic [DQ_W-1:0]     lanes_rx_rise_half;
    logic [DQ_W-1:0]     lanes_rx_fall_half;

    modport ctrl (
        output ctrl_clock, ctrl_clock_quadrature, capture_calibration_clock, mem_rst_b, cs_b,
        output memclk_pos_rise_half, memclk_pos_fall_half, memclk_neg_rise_half, memclk_neg_fall_half,
        output strobe_tx_rise_half, strobe_tx_fall_half, strobe_drive_enable,
        output lanes_tx_rise_half, lanes_tx_fall_half, lanes_drive_enable,
        input  strobe_rx_rise_half, strobe_rx_fall_half, lanes_rx_rise_half, lanes_rx_fall_half
    );
    modport port (
        input  ctrl_clock, ctrl_clock_quadrature, capture_calibration_clock, mem_rst_b, cs_b,
        input  memclk_pos_rise_half, memclk_pos_fall_half, memclk_neg_rise_half, memclk_neg_fall_half,
        input  strobe_tx_rise_half, strobe_tx_fall_half, strobe_drive_enable,
        input  lanes_tx_rise_half, lanes_tx_fall_half, lanes_drive_enable,
        output strobe_rx_rise_half, strobe_rx_fall_half, lanes_rx_rise_half, lanes_rx_fall_half
    );
endinterface

//--- src/dpf_pkg.sv
// constants, encodings and states shared by both ends of the psram port link
package dpf_pkg;
    localparam int          DQ_W          = 16;
    localparam int          STB_W         = 2;
    localparam longint      MEM_BITS      = 64'd268435456;
    localparam int          ADDR_W        = $clog2(MEM_BITS / DQ_W);
    localparam int          MEMCLK_MAX_MHZ = 250;
    localparam int          LINE_MAX_MBPS = 500;
    localparam int          SYS_MHZ       = 10;
    // divider: one memory clock period is eight system cycles
    localparam int          PH_W          = 3;
    localparam logic [2:0]  PH_LAST       = 3'h7;
    localparam logic [2:0]  PH_TAKE       = 3'h3;
    localparam int          CNT_W         = 4;
    localparam logic [3:0]  CMD_PERIODS   = 4'h2;
    localparam logic [3:0]  LAT_PERIODS   = 4'h6;
    localparam logic [3:0]  BEAT_PERIODS  = 4'h2;
    localparam int          CA_RD_BIT     = 15;
    // memory reset pulse after system reset, least time so round up
    localparam int          MEM_RST_NS    = 1000;
    localparam int          RCNT_W        = 8;
    localparam logic [7:0]  MEM_RST_CYC   = 8'((MEM_RST_NS * SYS_MHZ + 999) / 1000);
    localparam int          FIFO_W        = 2 * DQ_W;
    localparam int          FIFO_DEPTH    = 16;

    typedef enum logic [2:0] {
        DPF_IDLE = 3'h0,
        DPF_CMD  = 3'h1,
        DPF_LAT  = 3'h3,
        DPF_DATA = 3'h2,
        DPF_DONE = 3'h6
    } dpf_state_t;
endpackage

//--- src/dpf_port.sv
// double rate port cell between the fabric link and the memory pins
`timescale 1ns/10ps
module dpf_port
    import dpf_pkg::*;
(
    input  wire logic              clk_sys,         // system clock
    input  wire logic              rst_b,           // sync reset, active low
    dpf_link_if.port               link,            // fabric side
    output logic                   ck_p_o,          // memory clock, true leg
    output logic                   ck_n_o,          // memory clock, inverted leg
    output logic                   cs_pin_b,        // chip select pin
    output logic                   mem_rst_pin_b,   // memory reset pin
    input  wire logic [DQ_W-1:0]   dq_i,            // lane pins, level seen
    output logic      [DQ_W-1:0]   dq_o,            // lane pins, driven value
    output logic      [DQ_W-1:0]   dq_oe_b,         // low while driving lanes
    input  wire logic [STB_W-1:0]  rwds_i,          // strobe pins, level seen
    output logic      [STB_W-1:0]  rwds_o,          // strobe pins, driven value
    output logic      [STB_W-1:0]  rwds_oe_b        // low while driving strobe
);
    logic                ck_s1_r, ck_s2_r, ck_s3_r;
    logic                cal_s1_r, cal_s2_r, cal_s3_r;
    logic [DQ_W-1:0]     dq_s1_r, dq_s2_r;
    logic [STB_W-1:0]    rw_s1_r, rw_s2_r;
    logic                ck_rise, ck_fall, cal_rise, cal_fall;

    // clocks and pins arrive from outside, two flops before any use
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ck_s1_r  <= 1'b0;
            ck_s2_r  <= 1'b0;
            ck_s3_r  <= 1'b0;
            cal_s1_r <= 1'b0;
            cal_s2_r <= 1'b0;
            cal_s3_r <= 1'b0;
            dq_s1_r  <= '0;
            dq_s2_r  <= '0;
            rw_s1_r  <= '0;
            rw_s2_r  <= '0;
        end else begin
            ck_s1_r  <= link.ctrl_clock;
            ck_s2_r  <= ck_s1_r;
            ck_s3_r  <= ck_s2_r;
            cal_s1_r <= link.capture_calibration_clock;
            cal_s2_r <= cal_s1_r;
            cal_s3_r <= cal_s2_r;
            dq_s1_r  <= dq_i;
            dq_s2_r  <= dq_s1_r;
            rw_s1_r  <= rwds_i;
            rw_s2_r  <= rw_s1_r;
        end
    end

    // edges seen only after the second stage
    assign ck_rise  = ck_s2_r & ~ck_s3_r;
    assign ck_fall  = ~ck_s2_r & ck_s3_r;
    assign cal_rise = cal_s2_r & ~cal_s3_r;
    assign cal_fall = ~cal_s2_r & cal_s3_r;

    // outgoing half selection
    logic              ckp_r, ckp_nxt, ckn_r, ckn_nxt, cs_r, cs_nxt, mr_r, mr_nxt;
    logic [DQ_W-1:0]   dqo_r, dqo_nxt, dqoe_r, dqoe_nxt;
    logic [STB_W-1:0]  rwo_r, rwo_nxt, rwoe_r, rwoe_nxt;

    always_comb begin
        ckp_nxt  = ckp_r;
        ckn_nxt  = ckn_r;
        dqo_nxt  = dqo_r;
        dqoe_nxt = dqoe_r;
        rwo_nxt  = rwo_r;
        rwoe_nxt = rwoe_r;
        cs_nxt   = link.cs_b;
        mr_nxt   = link.mem_rst_b;
        if (ck_rise) begin
            ckp_nxt  = link.memclk_pos_rise_half;
            ckn_nxt  = link.memclk_neg_rise_half;
            dqo_nxt  = link.lanes_tx_rise_half;
            rwo_nxt  = link.strobe_tx_rise_half;
            dqoe_nxt = ~link.lanes_drive_enable;
            rwoe_nxt = ~link.strobe_drive_enable;
        end else if (ck_fall) begin
            ckp_nxt  = link.memclk_pos_fall_half;
            ckn_nxt  = link.memclk_neg_fall_half;
            dqo_nxt  = link.lanes_tx_fall_half;
            rwo_nxt  = link.strobe_tx_fall_half;
        end
    end

    // pins idle released: memory in reset, nothing driven
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ckp_r  <= 1'b0;
            ckn_r  <= 1'b1;
            dqo_r  <= '0;
            dqoe_r <= '1;
            rwo_r  <= '0;
            rwoe_r <= '1;
            cs_r   <= 1'b1;
            mr_r   <= 1'b0;
        end else begin
            ckp_r  <= ckp_nxt;
            ckn_r  <= ckn_nxt;
            dqo_r  <= dqo_nxt;
            dqoe_r <= dqoe_nxt;
            rwo_r  <= rwo_nxt;
            rwoe_r <= rwoe_nxt;
            cs_r   <= cs_nxt;
            mr_r   <= mr_nxt;
        end
    end

    assign ck_p_o        = ckp_r;
    assign ck_n_o        = ckn_r;
    assign dq_o          = dqo_r;
    assign dq_oe_b       = dqoe_r;
    assign rwds_o        = rwo_r;
    assign rwds_oe_b     = rwoe_r;
    assign cs_pin_b      = cs_r;
    assign mem_rst_pin_b = mr_r;

    // capture on the calibration clock, a quarter period after data moves
    logic [DQ_W-1:0]   rxr_r, rxr_nxt, rxf_r, rxf_nxt;
    logic [STB_W-1:0]  srr_r, srr_nxt, srf_r, srf_nxt;

    always_comb begin
        rxr_nxt = rxr_r;
        rxf_nxt = rxf_r;
        srr_nxt = srr_r;
        srf_nxt = srf_r;
        if (cal_rise) begin
            rxr_nxt = dq_s2_r;
            srr_nxt = rw_s2_r;
        end
        if (cal_fall) begin
            rxf_nxt = dq_s2_r;
            srf_nxt = rw_s2_r;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rxr_r <= '0;
            rxf_r <= '0;
            srr_r <= '0;
            srf_r <= '0;
        end else begin
            rxr_r <= rxr_nxt;
            rxf_r <= rxf_nxt;
            srr_r <= srr_nxt;
            srf_r <= srf_nxt;
        end
    end

    assign link.lanes_rx_rise_half  = rxr_r;
    assign link.lanes_rx_fall_half  = rxf_r;
    assign link.strobe_rx_rise_half = srr_r;
    assign link.strobe_rx_fall_half = srf_r;
endmodule
